// ===== sim/jtag_host_model.sv
// jtag host model: steps the tap and collects tdo bits
`timescale 1ns/1ns
`default_nettype none
module jtag_host_model (
  // link pins
  output logic            o_tck,
  output logic            o_tms,
  output logic            o_tdi,
  output logic            o_trst_n,
  input  wire logic       i_tdo,
  input  wire logic       i_tdo_oe
);
  logic [31:0] got;
  event        done;
  // a released tdo floats to its pull-up, never the last driven bit
  wire logic   tdo_w = i_tdo_oe ? i_tdo : 1'b1;

  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_n = 1'b1;
  end

  // one tck period; tck parks low between frames
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #200 o_tck = 1'b1;
    // tdo stands until this fall, so sampling late is safe
    #200 tdo = tdo_w;
    o_tck = 1'b0;
  endtask : step

  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din);
    logic b;
    got = '0;
    step(1'b1, 1'b1, b);
    if (ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      got[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    -> done;
  endtask : scan
endmodule : jtag_host_model
`default_nettype wire

// ===== sim/jtag_tap_port_asserts.sv
// concurrent checks on the jtag tap port, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module jtag_tap_port_asserts (
  // clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_srst,
  // link pins
  input wire logic                     i_tck,
  input wire logic                     i_trst_n,
  input wire logic                     o_tdo,
  input wire logic                     o_tdo_oe,
  // pin function
  input wire logic                     i_alt_function_select_bit_wr,
  input wire logic                     i_alt_function_select_bit,
  input wire logic                     i_lock_open,
  input wire logic                     i_commit_en,
  input wire logic                     o_pins_jtag,
  input wire logic                     o_pullup_en,
  // observation
  input wire logic [jtag_tap_pkg::BSR_W-1:0] o_bsr_out,
  input wire logic                     o_bsr_drive,
  input wire logic                     o_bsr_internal,
  input wire logic [jtag_tap_pkg::IR_W-1:0] o_instr,
  input wire jtag_tap_pkg::tap_state_t o_state
);
  import jtag_tap_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // trst is synchronised, so allow a few cycles before the hold is expected
  trst_hold_a: assert property ((!i_trst_n)[*4] |-> o_state == ST_RESET && !o_tdo_oe)
    else $error("tap not held in reset while trst low");
  reset_vals_a: assert property (disable iff (1'b0) i_srst |=> o_state == ST_RESET &&
    o_instr == INS_IDCODE && o_pins_jtag && o_pullup_en && !o_tdo_oe)
    else $error("reset values wrong");
  tlr_idcode_a: assert property (o_state == ST_RESET |=> o_instr == INS_IDCODE)
    else $error("idcode not loaded in reset state");
  tck_static_a: assert property ((i_trst_n && $stable(i_tck))[*6]
    |-> $stable(o_state) && $stable(o_instr))
    else $error("tap moved while tck static");
  // the pin is still high two samples back when a rise has been acted on
  step_on_rise_a: assert property ($changed(o_state) && o_state != ST_RESET
    |-> $past(i_tck, 2))
    else $error("tap stepped without a tck rise");
  tdo_on_fall_a: assert property ($changed(o_tdo) |-> !$past(i_tck, 2))
    else $error("tdo changed outside tck low phase");
  oe_shift_a: assert property (o_tdo_oe |-> o_pins_jtag && o_state inside
    {ST_SHIFT_DR, ST_EXIT1_DR, ST_SHIFT_IR, ST_EXIT1_IR})
    else $error("tdo driven outside shifting");
  test_quiet_a: assert property ((o_bsr_drive || o_bsr_internal) |=>
    $stable(o_bsr_out) && !(o_state == ST_SHIFT_DR && o_tdo_oe))
    else $error("chain touched under test instruction");
  gpio_guard_a: assert property (i_alt_function_select_bit_wr && !(i_lock_open && i_commit_en)
    |=> $stable(o_pins_jtag))
    else $error("pin function changed without commit");
  gpio_commit_a: assert property (i_alt_function_select_bit_wr && i_lock_open && i_commit_en
    |=> o_pins_jtag == $past(i_alt_function_select_bit) && o_pullup_en == o_pins_jtag)
    else $error("committed pin function not applied");

  // main scenarios reached
  upd_ir_c: cover property (o_state == ST_UPD_IR);
  shift_dr_c: cover property (o_state == ST_SHIFT_DR && o_tdo_oe);
  gpio_c: cover property (!o_pins_jtag);
endmodule : jtag_tap_port_asserts

bind jtag_tap_shift_port jtag_tap_port_asserts jtag_tap_port_asserts_inst (.*);
`default_nettype wire

// ===== sim/tb_jtag_tap_shift_port.sv
// self-checking bench for the jtag test access port
`timescale 1ns/1ns
`default_nettype none
module tb_jtag_tap_shift_port;
  import jtag_tap_pkg::*;
  logic             i_clk = 1'b0;
  logic             i_srst = 1'b1;
  logic             i_ce = 1'b1;
  logic             i_tck, i_tms, i_tdi, i_trst_n, o_tdo, o_tdo_oe;
  logic             i_alt_function_select_bit_wr = 1'b0;
  logic             i_alt_function_select_bit = 1'b1;
  logic             i_lock_open = 1'b0;
  logic             i_commit_en = 1'b0;
  logic [BSR_W-1:0] i_bsr_in = '0;
  logic [BSR_W-1:0] o_bsr_out;
  logic             o_pins_jtag, o_pullup_en, o_bsr_drive, o_bsr_internal;
  logic [IR_W-1:0]  o_instr;
  tap_state_t       o_state;
  logic [31:0]      exp_q[$];
  int               err_count = 0;
  int               n_tests = 0;
  integer           seed = 4;

  always #25 i_clk = ~i_clk;

  jtag_tap_shift_port jtag_tap_shift_port_inst (.*);
  jtag_host_model jtag_host_model_inst (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
    .o_trst_n(i_trst_n), .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // note the expected tdo word, then run the frame
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic [31:0] e);
    exp_q.push_back(e);
    jtag_host_model_inst.scan(ir, n, din);
    repeat (4) @(negedge i_clk);
  endtask : scan

  // tms pattern stepped lsb first
  task automatic walk(input logic [7:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++) jtag_host_model_inst.step(seq[i], 1'b1, b);
    repeat (4) @(negedge i_clk);
  endtask : walk

  task automatic alt_function_select_bit(input logic dat, input logic lk, input logic cm, input logic e);
    i_alt_function_select_bit = dat;
    i_lock_open = lk;
    i_commit_en = cm;
    i_alt_function_select_bit_wr = 1'b1;
    @(negedge i_clk);
    i_alt_function_select_bit_wr = 1'b0;
    @(negedge i_clk);
    check("pin function", {e, e}, {o_pins_jtag, o_pullup_en});
  endtask : alt_function_select_bit

  // each finished frame is compared with the oldest note
  always @(jtag_host_model_inst.done) begin
    check("tdo word", exp_q.pop_front(), jtag_host_model_inst.got);
  end

  initial begin
    logic [31:0] d, e;
    logic [7:0]  upd;
    logic [3:0]  codes [6];
    upd = '0;
    codes = '{INS_SAMPLE, INS_EXTEST, INS_INTEST, INS_BYPASS, INS_IDCODE, 4'h3};
    codes[5] = 4'h3 + 4'({$random(seed)} % 11);
    repeat (8) @(negedge i_clk);
    i_srst = 1'b0;
    check("state", ST_RESET, o_state);
    check("instr", INS_IDCODE, o_instr);
    check("pins", 32'h6, {o_pins_jtag, o_pullup_en, o_tdo_oe});
    walk(8'h00, 1);
    d = $random(seed);
    scan(1'b0, 32, d, ID_VALUE);
    $display("idcode test done");
    for (int k = 0; k < 6; k++) begin
      i_bsr_in = BSR_W'($random(seed));
      d = $random(seed);
      scan(1'b1, IR_W, {28'h0, codes[k]}, {28'h0, IR_CAPTURE});
      check("instr", codes[k], o_instr);
      check("test mode", {codes[k] == INS_EXTEST, codes[k] == INS_INTEST},
        {o_bsr_drive, o_bsr_internal});
      case (codes[k])
        INS_SAMPLE: e = i_bsr_in;
        INS_EXTEST, INS_INTEST: e = 32'h0000_00FF;
        INS_IDCODE: e = ID_VALUE;
        default: e = {d[6:0], 1'b0};
      endcase
      scan(1'b0, (codes[k] == INS_IDCODE) ? 32 : 8, d, e);
      if (codes[k] == INS_SAMPLE) upd = d[7:0];
      check("boundary", upd, o_bsr_out);
      $display("instruction %h test done", codes[k]);
    end
    walk(8'h01, 3);
    walk(8'h1F, 5);
    check("tms reset", {ST_RESET, INS_IDCODE}, {o_state, o_instr});
    walk(8'h00, 1);
    scan(1'b1, IR_W, {28'h0, INS_BYPASS}, {28'h0, IR_CAPTURE});
    walk(8'h01, 3);
    jtag_host_model_inst.o_trst_n = 1'b0;
    walk(8'h00, 2);
    check("trst", {ST_RESET, INS_IDCODE, 1'b0}, {o_state, o_instr, o_tdo_oe});
    jtag_host_model_inst.o_trst_n = 1'b1;
    walk(8'h00, 1);
    repeat (40) @(negedge i_clk);
    check("static tck", ST_IDLE, o_state);
    $display("reset tests done");
    // park in shift-dr so the gpio release has a driven tdo to take away
    walk(8'h01, 3);
    check("tdo driven", 1'b1, o_tdo_oe);
    alt_function_select_bit(1'b0, 1'b1, 1'b0, 1'b1);
    alt_function_select_bit(1'b0, 1'b0, 1'b1, 1'b1);
    alt_function_select_bit(1'b0, 1'b1, 1'b1, 1'b0);
    check("tdo released", 1'b0, o_tdo_oe);
    alt_function_select_bit(1'b1, 1'b1, 1'b1, 1'b1);
    check("tdo restored", 1'b1, o_tdo_oe);
    $display("pin function test done");
    final_report();
  end

  // hang guard, far beyond the expected run
  initial begin
    #1_000_000;
    err_count++;
    final_report();
  end
endmodule : tb_jtag_tap_shift_port
`default_nettype wire

// ===== verilog/jtag_tap_fsm.sv
// sixteen-state tap controller stepped by detected tck rising edges
`timescale 1ns/1ns
`default_nettype none
module jtag_tap_fsm (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ce,
  // sampled link
  input  wire logic                    i_step,
  input  wire logic                    i_tms,
  input  wire logic                    i_trst,
  // state
  output jtag_tap_pkg::tap_state_t     o_state
);
  import jtag_tap_pkg::*;

  tap_state_t state_r;
  tap_state_t state_nxt;

  // standard transition table, branch on tms
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:    state_nxt = i_tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_nxt = i_tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_nxt = i_tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_nxt = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_nxt = i_tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_nxt = i_tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_nxt = i_tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_nxt = i_tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_nxt = i_tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_nxt = i_tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_nxt = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_nxt = i_tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_nxt = i_tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_nxt = i_tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_nxt = i_tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_nxt = i_tms ? ST_SEL_DR   : ST_IDLE;
      default:     state_nxt = ST_RESET;
    endcase
  end

  // move only on a tck rise or trst; system reset wins over everything, trst wins over i_step only while i_ce is high
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= ST_RESET;
    end else if (i_ce) begin
      if (i_trst) begin
        state_r <= ST_RESET;
      end else if (i_step) begin
        state_r <= state_nxt;
      end
    end
  end

  assign o_state = state_r;

endmodule : jtag_tap_fsm
`default_nettype wire

// ===== verilog/jtag_tap_pkg.sv
// constants, instruction codes and tap states for the jtag test access port
package jtag_tap_pkg;

  localparam int          IR_W        = 4;
  localparam int          BSR_W       = 8;
  localparam int          ID_W        = 32;
  localparam int          PIN_CNT     = 4;
  // synchronised pin vector positions
  localparam int          PIN_TCK     = 0;
  localparam int          PIN_TMS     = 1;
  localparam int          PIN_TDI     = 2;
  localparam int          PIN_TRST_N  = 3;

  // instruction codes; anything else acts as bypass
  localparam logic [3:0]  INS_EXTEST  = 4'h0;
  localparam logic [3:0]  INS_INTEST  = 4'h1;
  localparam logic [3:0]  INS_SAMPLE  = 4'h2;
  localparam logic [3:0]  INS_IDCODE  = 4'hE;
  localparam logic [3:0]  INS_BYPASS  = 4'hF;
  // fixed pattern loaded into the instruction chain on capture
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  // identification word: value is arbitrary, bit 0 must be one
  localparam logic [31:0] ID_VALUE    = 32'h0A5A_0001;

  typedef enum logic [1:0] {
    DR_BYPASS,
    DR_IDCODE,
    DR_BOUNDARY,
    DR_HOLD
  } dr_sel_t;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } tap_state_t;

endpackage : jtag_tap_pkg

// ===== verilog/jtag_tap_shift_port.sv
// jtag test access port: pin sampling, tap, instruction and data chains
`timescale 1ns/1ns
`default_nettype none
module jtag_tap_shift_port (
  // clock, reset, enable
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  input  wire logic                          i_ce,
  // jtag pins, asynchronous to i_clk
  input  wire logic                          i_tck,
  input  wire logic                          i_tms,
  input  wire logic                          i_tdi,
  input  wire logic                          i_trst_n,
  output logic                               o_tdo,
  output logic                               o_tdo_oe,
  // pin function control from the gpio side
  input  wire logic                          i_alt_function_select_bit_wr,
  input  wire logic                          i_alt_function_select_bit,
  input  wire logic                          i_lock_open,
  input  wire logic                          i_commit_en,
  output logic                               o_pins_jtag,
  output logic                               o_pullup_en,
  // boundary cells
  input  wire logic [jtag_tap_pkg::BSR_W-1:0] i_bsr_in,
  output logic      [jtag_tap_pkg::BSR_W-1:0] o_bsr_out,
  output logic                               o_bsr_drive,
  output logic                               o_bsr_internal,
  // observation
  output logic      [jtag_tap_pkg::IR_W-1:0]  o_instr,
  output jtag_tap_pkg::tap_state_t           o_state
);
  import jtag_tap_pkg::*;

  logic [PIN_CNT-1:0] pin_raw;
  logic [PIN_CNT-1:0] pin_meta_r;
  logic [PIN_CNT-1:0] pin_sync_r;
  logic               tck_prev_r;
  logic               tck_rise;
  logic               tck_fall;
  logic               trst_act;
  tap_state_t         state;
  dr_sel_t            dr_sel;
  logic [IR_W-1:0]    ir_sh_r;
  logic [IR_W-1:0]    ir_upd_r;
  logic               byp_r;
  logic [ID_W-1:0]    id_sh_r;
  logic [BSR_W-1:0]   bsr_sh_r;
  logic [BSR_W-1:0]   bsr_upd_r;
  logic               tdo_r;
  logic               tdo_oe_r;
  logic               pin_alt_function_select_reg;

  assign pin_raw = {i_trst_n, i_tdi, i_tms, i_tck};

  // two-flop synchronisers, one per pin; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < PIN_CNT; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          pin_meta_r[g] <= 1'b1;
          pin_sync_r[g] <= 1'b1;
        end else if (i_ce) begin
          pin_meta_r[g] <= pin_raw[g];
          pin_sync_r[g] <= pin_meta_r[g];
        end
      end
    end
  endgenerate

  // tck edge finder; a stopped tck makes no edges so nothing steps, though trst still resets the tap
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tck_prev_r <= 1'b1;
    end else if (i_ce) begin
      tck_prev_r <= pin_sync_r[PIN_TCK];
    end
  end

  assign tck_rise = i_ce & pin_sync_r[PIN_TCK] & ~tck_prev_r;
  assign tck_fall = i_ce & ~pin_sync_r[PIN_TCK] & tck_prev_r;
  assign trst_act = ~pin_sync_r[PIN_TRST_N];

  jtag_tap_fsm jtag_tap_fsm_inst (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .i_step  (tck_rise),
    .i_tms   (pin_sync_r[PIN_TMS]),
    .i_trst  (trst_act),
    .o_state (state)
  );

  // instruction decode; unlisted codes fall back to the one-bit bypass
  always_comb begin
    case (ir_upd_r)
      INS_IDCODE: dr_sel = DR_IDCODE;
      INS_SAMPLE: dr_sel = DR_BOUNDARY;
      INS_EXTEST: dr_sel = DR_HOLD;
      INS_INTEST: dr_sel = DR_HOLD;
      default:    dr_sel = DR_BYPASS;
    endcase
  end

  // instruction chain: four-bit capture, shift from tdi, update
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (tck_rise) begin
      case (state)
        ST_CAP_IR:   ir_sh_r <= IR_CAPTURE;
        ST_SHIFT_IR: ir_sh_r <= {pin_sync_r[PIN_TDI], ir_sh_r[IR_W-1:1]};
        default:     ir_sh_r <= ir_sh_r;
      endcase
    end
  end

  // held instruction; every pass through test-logic-reset reloads idcode
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ir_upd_r <= INS_IDCODE;
    end else if (i_ce) begin
      if (state == ST_RESET) begin
        ir_upd_r <= INS_IDCODE;
      end else if (tck_rise && state == ST_UPD_IR) begin
        ir_upd_r <= ir_sh_r;
      end
    end
  end

  // bypass bit gives a tdi to tdo path only while bypass or an unlisted code is held
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      byp_r <= 1'b0;
    end else if (tck_rise && dr_sel == DR_BYPASS) begin
      if (state == ST_CAP_DR) begin
        byp_r <= 1'b0;
      end else if (state == ST_SHIFT_DR) begin
        byp_r <= pin_sync_r[PIN_TDI];
      end
    end
  end

  // identification chain, no update stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      id_sh_r <= ID_VALUE;
    end else if (tck_rise && dr_sel == DR_IDCODE) begin
      if (state == ST_CAP_DR) begin
        id_sh_r <= ID_VALUE;
      end else if (state == ST_SHIFT_DR) begin
        id_sh_r <= {pin_sync_r[PIN_TDI], id_sh_r[ID_W-1:1]};
      end
    end
  end

  // boundary chain; hold instructions leave shift and update stages alone
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bsr_sh_r <= '0;
    end else if (tck_rise && dr_sel == DR_BOUNDARY) begin
      if (state == ST_CAP_DR) begin
        bsr_sh_r <= i_bsr_in;
      end else if (state == ST_SHIFT_DR) begin
        bsr_sh_r <= {pin_sync_r[PIN_TDI], bsr_sh_r[BSR_W-1:1]};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bsr_upd_r <= '0;
    end else if (tck_rise && dr_sel == DR_BOUNDARY && state == ST_UPD_DR) begin
      bsr_upd_r <= bsr_sh_r;
    end
  end

  // tdo moves on the tck fall so a downstream part samples a stable bit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (i_ce && trst_act) begin
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= 1'b0;
      if (state == ST_SHIFT_IR) begin
        tdo_r    <= ir_sh_r[0];
        tdo_oe_r <= 1'b1;
      end else if (state == ST_SHIFT_DR) begin
        case (dr_sel)
          DR_BYPASS: begin
            tdo_r    <= byp_r;
            tdo_oe_r <= 1'b1;
          end
          DR_IDCODE: begin
            tdo_r    <= id_sh_r[0];
            tdo_oe_r <= 1'b1;
          end
          DR_BOUNDARY: begin
            tdo_r    <= bsr_sh_r[0];
            tdo_oe_r <= 1'b1;
          end
          default: tdo_oe_r <= 1'b0;
        endcase
      end
    end
  end

  // pin function: jtag after reset, released to gpio only through commit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_alt_function_select_reg <= 1'b1;
    end else if (i_ce && i_alt_function_select_bit_wr && i_lock_open && i_commit_en) begin
      pin_alt_function_select_reg <= i_alt_function_select_bit;
    end
  end

  assign o_tdo          = tdo_r;
  assign o_tdo_oe       = tdo_oe_r & pin_alt_function_select_reg;
  assign o_pins_jtag    = pin_alt_function_select_reg;
  assign o_pullup_en    = pin_alt_function_select_reg;
  assign o_bsr_out      = bsr_upd_r;
  assign o_bsr_drive    = (ir_upd_r == INS_EXTEST);
  assign o_bsr_internal = (ir_upd_r == INS_INTEST);
  assign o_instr        = ir_upd_r;
  assign o_state        = state;

endmodule : jtag_tap_shift_port
`default_nettype wire
